// ---- tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", nm, e, s); end end
module tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [15:0] hw0_i = 16'h0000;
  logic [15:0] hw1_i = 16'h0000;
  logic is32_i = 1'b0;
  logic cond_pass_i = 1'b1;
  logic [3:0] dly = 4'h0;
  logic instr_ready_o, wb_en_o, mem_req_o, mem_ack_i, done_o;
  logic undef_o, unpred_o, unpriv_o, push_o, match_o;
  logic [3:0] rd_base_idx_o, rd_src_idx_o, rd_off_idx_o, wb_idx_o;
  logic [31:0] base_val_i, src_val_i, off_val_i, wb_data_o, mem_addr_o, mem_wdata_o;
  logic [31:0] st_addr, st_data, wb_val;
  logic [3:0] wb_idx_got;
  int st_cnt = 0, wb_cnt = 0, bad_count = 0, n_tests = 0, cyc = 0;
  always #25 clk_i = ~clk_i;
  // register file: values tell the index they came from
  assign base_val_i = {24'h200000, rd_base_idx_o, 4'h0};
  assign src_val_i = {28'hC0DE5A7, rd_src_idx_o};
  assign off_val_i = {28'h0000001, rd_off_idx_o};
  wsde_top dut (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .instr_valid_i(instr_valid_i),
    .hw0_i(hw0_i),
    .hw1_i(hw1_i),
    .is32_i(is32_i),
    .cond_pass_i(cond_pass_i),
    .instr_ready_o(instr_ready_o),
    .rd_base_idx_o(rd_base_idx_o),
    .rd_src_idx_o(rd_src_idx_o),
    .rd_off_idx_o(rd_off_idx_o),
    .base_val_i(base_val_i),
    .src_val_i(src_val_i),
    .off_val_i(off_val_i),
    .wb_en_o(wb_en_o),
    .wb_idx_o(wb_idx_o),
    .wb_data_o(wb_data_o),
    .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .mem_ack_i(mem_ack_i),
    .done_o(done_o),
    .undef_o(undef_o),
    .unpred_o(unpred_o),
    .unpriv_o(unpriv_o),
    .push_o(push_o),
    .match_o(match_o)
  );
  wsde_mem_model u_mem (.clk_i(clk_i), .rstn_i(rstn_i), .mem_req_i(mem_req_o),
    .delay_i(dly), .mem_ack_o(mem_ack_i));
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (mem_req_o === 1'b1 && mem_ack_i === 1'b1)
    begin
      st_cnt <= st_cnt + 1;
      st_addr <= mem_addr_o;
      st_data <= mem_wdata_o;
    end
    if (wb_en_o === 1'b1)
    begin
      wb_cnt <= wb_cnt + 1;
      wb_val <= wb_data_o;
      wb_idx_got <= wb_idx_o;
    end
    if (cyc == 3000)
    begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----
  // one instruction; zero address means no store, zero wv means no writeback
  // ----
  task automatic xfer(input logic [31:0] i, input logic c, input logic [3:0] t,
    input logic [31:0] ad, input logic [31:0] wv, input logic [4:0] f);
    int n0, w0, k;
    n0 = st_cnt;
    w0 = wb_cnt;
    @(negedge clk_i);
    is32_i = (i[31:27] == 5'h1F);
    hw0_i = i[31:16];
    hw1_i = i[15:0];
    cond_pass_i = c;
    instr_valid_i = 1'b1;
    k = 0;
    while (instr_ready_o !== 1'b1 && k < 20)
    begin
      @(negedge clk_i);
      k++;
    end
    @(negedge clk_i);
    instr_valid_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 40)
    begin
      @(negedge clk_i);
      k++;
    end
    `CHK("done", 1'b1, done_o)
    `CHK("stores", (ad != 32'h0) ? n0 + 1 : n0, st_cnt)
    `CHK("wbacks", (wv != 32'h0) ? w0 + 1 : w0, wb_cnt)
    if (ad != 32'h0)
    begin
      `CHK("addr", ad, st_addr)
      `CHK("data", {28'hC0DE5A7, t}, st_data)
    end
    if (wv != 32'h0)
    begin
      `CHK("wb data", wv, wb_val)
      `CHK("wb idx", i[19:16], wb_idx_got)
    end
    `CHK("flags", f, {undef_o, unpred_o, unpriv_o, push_o, match_o})
  endtask
  task automatic t_short();
    xfer(32'h67D30000, 1'b1, 4'h3, 32'h2000009C, 32'h0, 5'h01);
  endtask
  task automatic t_stack();
    dly = 4'h3;
    xfer(32'h95FF0000, 1'b1, 4'h5, 32'h200004CC, 32'h0, 5'h01);
  endtask
  task automatic t_long();
    xfer(32'hF8CDFFFF, 1'b1, 4'hF, 32'h200010CF, 32'h0, 5'h09);
    xfer(32'hF8CF1004, 1'b1, 4'h1, 32'h0, 32'h0, 5'h11);
    xfer(32'hF84F1C10, 1'b1, 4'h1, 32'h0, 32'h0, 5'h11);
    xfer(32'hF84F6007, 1'b1, 4'h6, 32'h0, 32'h0, 5'h11);
  endtask
  task automatic t_indexed();
    dly = 4'h1;
    xfer(32'hF8441C10, 1'b1, 4'h1, 32'h20000030, 32'h0, 5'h01);
    xfer(32'hF8441F10, 1'b1, 4'h1, 32'h20000050, 32'h20000050, 5'h01);
    xfer(32'hF8441D10, 1'b1, 4'h1, 32'h20000030, 32'h20000030, 5'h01);
    xfer(32'hF8441B10, 1'b1, 4'h1, 32'h20000040, 32'h20000050, 5'h01);
    xfer(32'hF8441910, 1'b1, 4'h1, 32'h20000040, 32'h20000030, 5'h01);
    xfer(32'hF844DF10, 1'b1, 4'hD, 32'h20000050, 32'h20000050, 5'h01);
  endtask
  task automatic t_dispatch();
    xfer(32'hF8441E10, 1'b1, 4'h1, 32'h0, 32'h0, 5'h05);
    xfer(32'hF84D1D04, 1'b1, 4'h1, 32'h0, 32'h0, 5'h03);
    xfer(32'hF8441810, 1'b1, 4'h1, 32'h0, 32'h0, 5'h11);
    xfer(32'hF8444F10, 1'b1, 4'h4, 32'h20000050, 32'h20000050, 5'h09);
    xfer(32'hF844FC10, 1'b1, 4'hF, 32'h20000030, 32'h0, 5'h09);
    xfer(32'h00000000, 1'b1, 4'h0, 32'h0, 32'h0, 5'h00);
  endtask
  task automatic t_regoff();
    xfer(32'h50990000, 1'b1, 4'h1, 32'h20000042, 32'h0, 5'h01);
    for (int k = 0; k < 4; k++)
      xfer({16'hF845, 16'h6007 | (16'(k) << 4)}, 1'b1, 4'h6,
        32'h20000050 + (32'h17 << k), 32'h0, 5'h01);
    xfer(32'hF845600D, 1'b1, 4'h6, 32'h2000006D, 32'h0, 5'h09);
    xfer(32'hF845F007, 1'b1, 4'hF, 32'h20000067, 32'h0, 5'h09);
  endtask
  task automatic t_cond();
    xfer(32'h67D30000, 1'b0, 4'h3, 32'h0, 32'h0, 5'h01);
    xfer(32'hF8441F10, 1'b0, 4'h1, 32'h0, 32'h0, 5'h01);
  endtask
  initial
  begin
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    t_short();
    t_stack();
    t_long();
    t_indexed();
    t_dispatch();
    t_regoff();
    t_cond();
    summarize();
  end
endmodule

// ---- wsde_mem_model.sv ----
`timescale 1ns/1ps
module wsde_mem_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // store port
  input wire logic mem_req_i,
  input wire logic [3:0] delay_i,
  output logic mem_ack_o
);
  logic [3:0] wait_ff;
  // combinational ack so a zero delay answers in the first request cycle
  assign mem_ack_o = mem_req_i && (wait_ff == delay_i);
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wait_ff <= 4'h0;
    else if (mem_ack_o)
      wait_ff <= 4'h0;
    else if (mem_req_i)
      wait_ff <= wait_ff + 4'h1;
  end
endmodule

// ---- wsde_pkg.sv ----
package wsde_pkg;
  // ---------------------------------------------------------------
  // register indices and widths
  // ---------------------------------------------------------------
  localparam logic [3:0] SP_IDX = 4'hD;
  localparam logic [3:0] PC_IDX = 4'hF;
  localparam logic [3:0] ALL_ONES_IDX = 4'hF;
  localparam logic [7:0] PUSH_OFFSET = 8'h04;
  localparam int REG_W = 32;
  localparam int IDX_W = 4;

  // ---------------------------------------------------------------
  // 16-bit encodings: opcode prefixes
  // ---------------------------------------------------------------
  localparam logic [4:0] T1_IMM_OP = 5'h0C;
  localparam logic [4:0] T2_SP_OP = 5'h12;
  localparam logic [6:0] T1_REG_OP = 7'h28;

  // ---------------------------------------------------------------
  // 32-bit encodings: first halfword bits 15:4; register-form zero padding is second halfword bits 11:6
  // ---------------------------------------------------------------
  localparam logic [11:0] T3_IMM_OP = 12'hF8C;
  localparam logic [11:0] T4_IDX_OP = 12'hF84;
  localparam logic [5:0] T2_REG_ZERO = 6'h00;

  // ---------------------------------------------------------------
  // decoded operation kinds
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    WSDE_OP_NONE,
    WSDE_OP_STORE,
    WSDE_OP_UNPRIV,
    WSDE_OP_PUSH,
    WSDE_OP_UNDEF
  } wsde_op_e;

  typedef enum logic [1:0] {
    WSDE_ST_IDLE,
    WSDE_ST_MEM,
    WSDE_ST_DONE
  } wsde_state_e;
endpackage

// ---- wsde_shift.sv ----
`timescale 1ns/1ps
// registered logical left shift of the offset register by 0..3
module wsde_shift (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // operand
  input wire logic load_i,
  input wire logic [31:0] val_i,
  input wire logic [1:0] amt_i,
  // result
  output logic [31:0] val_o
);
  logic [31:0] nxt_val;
  logic [31:0] val_ff;

  assign nxt_val = val_i << amt_i;
  assign val_o = val_ff;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      val_ff <= 32'h0;
    else if (load_i)
      val_ff <= nxt_val;
  end
endmodule

// ---- wsde_top.sv ----
`timescale 1ns/1ps
// How it works
// RULE1: short form: 5-bit offset times four, zero-extended, offset mode, no writeback.
// RULE2: stack form: base forced to 13, 8-bit offset times four, no writeback.
// RULE3: long form: 12-bit unscaled offset, no writeback; source 15 is unpredictable.
// RULE4: 32-bit stores with base field all ones are undefined; the code dispatches an indexed P=1 U=1 W=0 one as unprivileged instead.
// RULE5: indexed form: P pre-index, U add, W writeback, 8-bit offset.
// RULE6: indexed with P=1 U=1 W=0 dispatches as unprivileged store.
// RULE7: indexed base 13, P1 U0 W1, offset four dispatches as push.
// RULE8: indexed with P=0 and W=0 is undefined.
// RULE9: indexed: source 15, or writeback with base equal source, unpredictable.
// RULE10: offset address is base plus/minus offset; used when pre-indexing, else base.
// RULE11: whole 32-bit source value stored as one word.
// RULE12: writeback puts the offset address into the base register.
// RULE13: offset ranges 0-124, 0-1020, 0-4095 and 8-bit follow from field widths.
// RULE14: register form shifts offset left 0..3; 16-bit form shift zero.
// RULE15: register form address is base plus shifted offset, no writeback.
// RULE16: 32-bit register form: source 15 or offset reg 13/15 unpredictable.
// RULE17: stack pointer allowed as source or base register.
// RULE18: memory write and base update only when condition passes.
module wsde_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // instruction from decode
  input wire logic instr_valid_i,
  input wire logic [15:0] hw0_i,
  input wire logic [15:0] hw1_i,
  input wire logic is32_i,
  input wire logic cond_pass_i,
  output logic instr_ready_o,
  // register file read ports
  output logic [3:0] rd_base_idx_o,
  output logic [3:0] rd_src_idx_o,
  output logic [3:0] rd_off_idx_o,
  input wire logic [31:0] base_val_i,
  input wire logic [31:0] src_val_i,
  input wire logic [31:0] off_val_i,
  // base writeback
  output logic wb_en_o,
  output logic [3:0] wb_idx_o,
  output logic [31:0] wb_data_o,
  // memory store port
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  // status
  output logic done_o,
  output logic undef_o,
  output logic unpred_o,
  output logic unpriv_o,
  output logic push_o,
  output logic match_o
);
  // ---------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rstn;

  // release is stretched through two flops so no flop leaves reset mid-cycle
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rstn = rst_sync_ff;

  // ---------------------------------------------------------------
  // encoding recognition
  // ---------------------------------------------------------------
  wire is_t1_imm = !is32_i && (hw0_i[15:11] == wsde_pkg::T1_IMM_OP);
  wire is_t2_sp = !is32_i && (hw0_i[15:11] == wsde_pkg::T2_SP_OP);
  wire is_t1_reg = !is32_i && (hw0_i[15:9] == wsde_pkg::T1_REG_OP);
  wire is_t3_imm = is32_i && (hw0_i[15:4] == wsde_pkg::T3_IMM_OP);
  wire is_t4_idx = is32_i && (hw0_i[15:4] == wsde_pkg::T4_IDX_OP) && hw1_i[11];
  // register form shares the indexed prefix; bit 11 low and zero padding set it apart
  wire is_t2_reg = is32_i && (hw0_i[15:4] == wsde_pkg::T4_IDX_OP) && !hw1_i[11]
    && (hw1_i[11:6] == wsde_pkg::T2_REG_ZERO);
  wire is_any = is_t1_imm | is_t2_sp | is_t1_reg | is_t3_imm | is_t4_idx | is_t2_reg;
  wire is_reg_form = is_t1_reg | is_t2_reg;

  // ---------------------------------------------------------------
  // field extraction
  // ---------------------------------------------------------------
  // 16-bit register fields reach only the low eight registers, so the top index bit is zero
  wire [3:0] base_reg_field = is32_i ? hw0_i[3:0] : {1'b0, hw0_i[5:3]};
  wire [3:0] source_reg_field = is32_i ? hw1_i[15:12] :
    (is_t2_sp ? {1'b0, hw0_i[10:8]} : {1'b0, hw0_i[2:0]});
  wire [3:0] offset_reg_field = is32_i ? hw1_i[3:0] : {1'b0, hw0_i[8:6]};
  wire [4:0] short_offset_field = hw0_i[10:6];
  wire [7:0] byte_offset_field = is32_i ? hw1_i[7:0] : hw0_i[7:0];
  wire [11:0] long_offset_field = hw1_i[11:0];
  wire [1:0] shift_amount_field = hw1_i[5:4];
  // index, add and writeback bits exist only in the indexed form
  wire p_bit = hw1_i[10];
  wire u_bit = hw1_i[9];
  wire w_bit = hw1_i[8];

  // stack pointer is legal in either slot, so no check on index 13 there (see RULE17)
  wire [3:0] base_idx = is_t2_sp ? wsde_pkg::SP_IDX : base_reg_field; // see RULE2

  // zero-extended immediates; field widths bound the ranges (see RULE13)
  wire [31:0] imm_short = {25'h0, short_offset_field, 2'h0}; // see RULE1
  wire [31:0] imm_sp = {22'h0, byte_offset_field, 2'h0}; // see RULE2
  wire [31:0] imm_long = {20'h0, long_offset_field}; // see RULE3
  wire [31:0] imm_idx = {24'h0, byte_offset_field}; // see RULE5

  wire [31:0] imm32 = is_t1_imm ? imm_short :
    is_t2_sp ? imm_sp :
    is_t3_imm ? imm_long : imm_idx;

  // addressing mode; only the indexed form has P/U/W (see RULE1, RULE3, RULE15)
  wire idx_pre = is_t4_idx ? p_bit : 1'b1; // see RULE5
  wire idx_add = is_t4_idx ? u_bit : 1'b1; // see RULE5
  wire idx_wb = is_t4_idx ? w_bit : 1'b0; // see RULE5

  // ---------------------------------------------------------------
  // classification
  // ---------------------------------------------------------------
  wire base_ones = is32_i && (base_reg_field == wsde_pkg::ALL_ONES_IDX);
  wire sel_unpriv = is_t4_idx && p_bit && u_bit && !w_bit; // see RULE6
  wire sel_push = is_t4_idx && (base_reg_field == wsde_pkg::SP_IDX) && p_bit
    && !u_bit && w_bit && (byte_offset_field == wsde_pkg::PUSH_OFFSET); // see RULE7
  wire undef_base = (is_t3_imm | is_t4_idx | is_t2_reg) && base_ones; // see RULE4
  wire undef_mode = is_t4_idx && !p_bit && !w_bit; // see RULE8
  // unprivileged dispatch is checked before the undefined cases
  wire sel_undef = !sel_unpriv && (undef_base || undef_mode);
  // unpredictable stores still execute; the flag only reports them
  wire src_pc = source_reg_field == wsde_pkg::PC_IDX;
  wire unp_t3 = is_t3_imm && src_pc; // see RULE3
  wire unp_t4 = is_t4_idx && (src_pc || w_bit && base_reg_field == source_reg_field); // see RULE9
  wire unp_reg = is_t2_reg && (src_pc || offset_reg_field == wsde_pkg::SP_IDX
    || offset_reg_field == wsde_pkg::PC_IDX); // see RULE16
  wire sel_unpred = unp_t3 | unp_t4 | unp_reg;

  // priority: dispatch, then undefined, then push, then plain store
  wsde_pkg::wsde_op_e dec_op;
  assign dec_op = !is_any ? wsde_pkg::WSDE_OP_NONE :
    sel_unpriv ? wsde_pkg::WSDE_OP_UNPRIV :
    sel_undef ? wsde_pkg::WSDE_OP_UNDEF :
    sel_push ? wsde_pkg::WSDE_OP_PUSH : wsde_pkg::WSDE_OP_STORE;

  // ---------------------------------------------------------------
  // captured instruction state
  // ---------------------------------------------------------------
  wsde_pkg::wsde_state_e state_ff;
  wsde_pkg::wsde_state_e nxt_state;
  // decoded fields, held for the whole instruction
  logic [3:0] base_idx_ff;
  logic [3:0] src_idx_ff;
  logic [3:0] off_idx_ff;
  logic [31:0] imm_ff;
  logic pre_ff;
  logic add_ff;
  logic wb_ff;
  logic reg_form_ff;
  logic exec_ff;
  logic [1:0] shamt_ff;
  // pipeline results
  logic [31:0] addr_ff;
  logic [31:0] wdata_ff;
  logic [31:0] offaddr_ff;
  // status levels
  logic undef_ff;
  logic unpred_ff;
  logic unpriv_ff;
  logic push_ff;
  logic match_ff;
  logic done_ff;
  logic [31:0] shifted_off;

  // gated by ready: a valid held past the capture edge must not start a second run
  wire take = instr_valid_i && instr_ready_o;
  // operand stage: one cycle after take the register file answers the indices
  logic opnd_ff;

  // registered left shift of the offset register (see RULE14)
  wsde_shift u_shift (
    .clk_i(clk_i),
    .rstn_i(rstn),
    .load_i(opnd_ff),
    .val_i(off_val_i),
    .amt_i(shamt_ff),
    .val_o(shifted_off)
  );
  logic calc_ff;

  // ---------------------------------------------------------------
  // address computation
  // ---------------------------------------------------------------
  // subtraction wraps at 32 bits, like the address space
  wire [31:0] imm_sum = add_ff ? base_val_i + imm_ff : base_val_i - imm_ff; // see RULE10
  wire [31:0] reg_sum = addr_ff + shifted_off; // see RULE15
  wire [31:0] eff_addr = pre_ff ? imm_sum : base_val_i; // see RULE10

  always_ff @(posedge clk_i or negedge rstn)
  begin
    if (!rstn)
    begin
      base_idx_ff <= 4'h0;
      src_idx_ff <= 4'h0;
      off_idx_ff <= 4'h0;
      imm_ff <= 32'h0;
      pre_ff <= 1'b0;
      add_ff <= 1'b0;
      wb_ff <= 1'b0;
      reg_form_ff <= 1'b0;
      exec_ff <= 1'b0;
      shamt_ff <= 2'h0;
      undef_ff <= 1'b0;
      unpred_ff <= 1'b0;
      unpriv_ff <= 1'b0;
      push_ff <= 1'b0;
      match_ff <= 1'b0;
    end
    else if (take)
    begin
      base_idx_ff <= base_idx;
      src_idx_ff <= source_reg_field;
      off_idx_ff <= offset_reg_field;
      imm_ff <= imm32;
      pre_ff <= idx_pre;
      add_ff <= idx_add;
      wb_ff <= idx_wb;
      reg_form_ff <= is_reg_form;
      shamt_ff <= is_t2_reg ? shift_amount_field : 2'h0; // see RULE14
      // only a plain word store executes here; others are flagged for dispatch
      exec_ff <= cond_pass_i && (dec_op == wsde_pkg::WSDE_OP_STORE); // see RULE18
      // status levels stand until the next capture
      undef_ff <= dec_op == wsde_pkg::WSDE_OP_UNDEF;
      unpred_ff <= sel_unpred && dec_op == wsde_pkg::WSDE_OP_STORE;
      unpriv_ff <= dec_op == wsde_pkg::WSDE_OP_UNPRIV;
      push_ff <= dec_op == wsde_pkg::WSDE_OP_PUSH;
      match_ff <= is_any;
    end
  end

  // ---------------------------------------------------------------
  // operand and address pipeline
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn)
  begin
    if (!rstn)
    begin
      opnd_ff <= 1'b0;
      calc_ff <= 1'b0;
      addr_ff <= 32'h0;
      wdata_ff <= 32'h0;
      offaddr_ff <= 32'h0;
    end
    else
    begin
      opnd_ff <= take;
      calc_ff <= opnd_ff;
      if (opnd_ff)
      begin
        addr_ff <= reg_form_ff ? base_val_i : eff_addr;
        offaddr_ff <= imm_sum;
        wdata_ff <= src_val_i; // see RULE11
      end
      // register form adds the shifted offset one cycle later
      else if (calc_ff && reg_form_ff)
        addr_ff <= reg_sum;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      // idle until the address pipeline raises calc_ff
      wsde_pkg::WSDE_ST_IDLE:
        nxt_state = wsde_pkg::WSDE_ST_IDLE;
      wsde_pkg::WSDE_ST_MEM:
        if (mem_ack_i)
          nxt_state = wsde_pkg::WSDE_ST_DONE;
      wsde_pkg::WSDE_ST_DONE:
        nxt_state = wsde_pkg::WSDE_ST_IDLE;
    endcase
    // after the address settles, skip memory when nothing executes
    if (calc_ff)
      nxt_state = exec_ff ? wsde_pkg::WSDE_ST_MEM : wsde_pkg::WSDE_ST_DONE; // see RULE18
  end

  // ready drops at capture and comes back with the retire pulse
  logic busy_ff;
  always_ff @(posedge clk_i or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= wsde_pkg::WSDE_ST_IDLE;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      done_ff <= state_ff == wsde_pkg::WSDE_ST_DONE;
      if (take)
        busy_ff <= 1'b1;
      else if (state_ff == wsde_pkg::WSDE_ST_DONE)
        busy_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // handshake and register file indices
  assign instr_ready_o = !busy_ff;
  assign rd_base_idx_o = base_idx_ff;
  assign rd_src_idx_o = src_idx_ff;
  assign rd_off_idx_o = off_idx_ff;

  // store port; address and data stand until the acknowledge
  assign mem_req_o = state_ff == wsde_pkg::WSDE_ST_MEM;
  assign mem_addr_o = addr_ff;
  assign mem_wdata_o = wdata_ff; // see RULE11

  // base update lands with the store acknowledge, pre or post alike
  assign wb_en_o = mem_req_o && mem_ack_i && wb_ff; // see RULE12
  assign wb_idx_o = base_idx_ff;
  assign wb_data_o = offaddr_ff; // see RULE12

  // status levels and the retire pulse
  assign done_o = done_ff;
  assign undef_o = undef_ff;
  assign unpred_o = unpred_ff;
  assign unpriv_o = unpriv_ff;
  assign push_o = push_ff;
  assign match_o = match_ff;
endmodule

// ---- wsde_top_chk.sv ----
`timescale 1ns/1ps
module wsde_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // instruction side
  input wire logic instr_valid_i,
  input wire logic instr_ready_o,
  input wire logic [15:0] hw0_i,
  input wire logic [15:0] hw1_i,
  input wire logic is32_i,
  input wire logic cond_pass_i,
  input wire logic [3:0] rd_base_idx_o,
  // writeback and store
  input wire logic wb_en_o,
  input wire logic [3:0] wb_idx_o,
  input wire logic mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  // status
  input wire logic done_o,
  input wire logic undef_o,
  input wire logic unpred_o,
  input wire logic unpriv_o,
  input wire logic push_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic take;
  logic t3;
  assign take = instr_valid_i && instr_ready_o;
  assign t3 = take && is32_i && hw0_i[15:4] == wsde_pkg::T3_IMM_OP;
  // ----
  // assertions
  // ----
  chk_wb_on_ack:
  assert property (wb_en_o |-> mem_req_o && mem_ack_i && wb_idx_o == rd_base_idx_o)
    else $error("writeback without accepted store or wrong index");
  chk_req_holds:
  assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_addr_o) && $stable(mem_wdata_o))
    else $error("store request changed before acceptance");
  chk_retire_ack:
  assert property (mem_req_o && mem_ack_i |=> !mem_req_o ##1 done_o)
    else $error("store not retired two cycles after acceptance");
  chk_cond_fail:
  assert property (take && !cond_pass_i |-> ##1 (!mem_req_o && !wb_en_o)[*3] ##1 done_o)
    else $error("failed condition still acted or did not retire");
  chk_undef_quiet:
  assert property (undef_o |-> !mem_req_o)
    else $error("undefined encoding made a store");
  chk_dispatch_quiet:
  assert property (unpriv_o || push_o |-> !mem_req_o)
    else $error("dispatched encoding made a store");
  chk_sp_base:
  assert property (take && !is32_i && hw0_i[15:11] == wsde_pkg::T2_SP_OP |=>
    rd_base_idx_o == wsde_pkg::SP_IDX)
    else $error("stack form did not read the stack pointer");
  chk_long_pc_src:
  assert property (t3 && hw1_i[15:12] == wsde_pkg::PC_IDX &&
    hw0_i[3:0] != wsde_pkg::ALL_ONES_IDX |=> unpred_o && !undef_o)
    else $error("long form source 15 not unpredictable");
  chk_long_undef:
  assert property (t3 && hw0_i[3:0] == wsde_pkg::ALL_ONES_IDX |=> undef_o)
    else $error("long form base all ones not undefined");
  chk_push_pick:
  assert property (take && is32_i && hw0_i == {wsde_pkg::T4_IDX_OP, wsde_pkg::SP_IDX} &&
    hw1_i[11:0] == 12'hD04 |=> push_o)
    else $error("push pattern not dispatched");
  cov_wb: cover property (wb_en_o);
  cov_stall: cover property (mem_req_o && !mem_ack_i);
  cov_cond: cover property (take && !cond_pass_i);
endmodule

bind wsde_top wsde_chk u_chk (
  .clk_i(clk_i),
  .rstn_i(rstn_i),
  .instr_valid_i(instr_valid_i),
  .instr_ready_o(instr_ready_o),
  .hw0_i(hw0_i),
  .hw1_i(hw1_i),
  .is32_i(is32_i),
  .cond_pass_i(cond_pass_i),
  .rd_base_idx_o(rd_base_idx_o),
  .wb_en_o(wb_en_o),
  .wb_idx_o(wb_idx_o),
  .mem_req_o(mem_req_o),
  .mem_ack_i(mem_ack_i),
  .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o),
  .done_o(done_o),
  .undef_o(undef_o),
  .unpred_o(unpred_o),
  .unpriv_o(unpriv_o),
  .push_o(push_o)
);
